// *** src/sfd_defs.svh ***
`ifndef SFD_DEFS_SVH
`define SFD_DEFS_SVH
// ****************************************
// Opcodes
// ****************************************
`define SFD_OP_NOP   8'h00
`define SFD_OP_ARM   8'h66
`define SFD_OP_RST   8'h99
`define SFD_OP_EQ    8'h38
`define SFD_OP_XQ    8'hff
`define SFD_OP_READ_STATUS_CMD  8'h05
`define SFD_OP_WRITE_STATUS_CMD  8'h01
`define SFD_OP_READ_CONFIG_CMD  8'h35
`define SFD_OP_FRD   8'h0b
`define SFD_OP_QOR   8'h6b
`define SFD_OP_QIOR  8'heb
`define SFD_OP_DOR   8'h3b
`define SFD_OP_DIOR  8'hbb
`define SFD_OP_SB    8'hc0
`define SFD_OP_QWR   8'h0c
`define SFD_OP_SWR   8'hec
`define SFD_OP_WRITE_ENABLE_CMD  8'h06
`define SFD_OP_WRITE_DISABLE_CMD  8'h04
`define SFD_OP_SER   8'h20
`define SFD_OP_BER   8'hd8
`define SFD_OP_CER   8'hc7
`define SFD_OP_PP    8'h02
`define SFD_OP_QPP   8'h32
`define SFD_OP_WBPR  8'h42
// ****************************************
// Field counts
// ****************************************
`define SFD_ADDR3    2'h3
`define SFD_DUM1     2'h1
`define SFD_DUM3     2'h3
`define SFD_ONE      9'h001
`define SFD_WRITE_STATUS_CMD_N   9'h002
`define SFD_BPR_MAX  9'h012
`define SFD_PAGE_MAX 9'h100
`define SFD_BURST    9'h008
`define SFD_EDGES_Q  4'h2
`define SFD_EDGES_1  4'h8
// ****************************************
// Timing
// ****************************************
`define SFD_CLK_NS   10
`define SFD_PROTECT_ENABLE_WRITE_TIME_NS 10000
`endif

// *** src/sfd_pkg.sv ***
package sfd_pkg;
    // Lane width of the data phase
    typedef enum logic [1:0] {SFD_IO1, SFD_IO2, SFD_IO4} sfd_width_t;
    // One decoded command
    typedef struct packed {
        logic [7:0] opcode;
        logic [1:0] addr_bytes;
        logic [1:0] dummy;
        logic [8:0] data_min;
        logic [8:0] data_max;
        logic       data_unlim;
        sfd_width_t width;
    } sfd_cmd_t;
    // Decode result
    typedef struct packed {
        logic     ok;
        sfd_cmd_t cmd;
    } sfd_dec_t;
    // Link side state
    typedef struct packed {
        logic [3:0] cnt;
        logic [7:0] sh1;
        logic [7:0] sh4;
        logic [7:0] op1;
        logic [7:0] op4;
        logic       f1;
        logic       f4;
    } sfd_link_t;
    // Core side state
    typedef struct packed {
        logic [2:0]  f1s;
        logic [2:0]  f4s;
        logic [1:0]  wps;
        logic        quad;
        logic        armed;
        logic        protect_pin_enable;
        logic        locked;
        logic        ind;      // Volatility indicator, its own flop
        logic        busy;
        logic [19:0] bcnt;
        logic        hwp;
        logic        cmd_v;
        logic        cmd_rej;
        logic        rst_p;
        sfd_cmd_t    cmd;
    } sfd_core_t;
endpackage : sfd_pkg

// *** src/sfd_decoder.sv ***
`timescale 1ns/1ps
`include "sfd_defs.svh"
module sfd_decoder #(
    parameter int PROTECT_ENABLE_WRITE_TIME_CYCLES = (`SFD_PROTECT_ENABLE_WRITE_TIME_NS + `SFD_CLK_NS - 1) / `SFD_CLK_NS
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_sck,
    input  wire logic             i_cs_n,
    input  wire logic [3:0]       i_sio,
    input  wire logic             i_wp_n,
    input  wire logic             i_quad_pin_config,
    input  wire logic             i_nv_protect_pin_enable,
    input  wire logic             i_nv_locked,
    input  wire logic             i_protect_pin_enable_wr,
    input  wire logic             i_protect_pin_enable_val,
    input  wire logic             i_lock_set,
    output logic                  o_cmd_valid,
    output logic                  o_cmd_reject,
    output sfd_pkg::sfd_cmd_t     o_cmd,
    output logic                  o_soft_reset,
    output logic                  o_quad_mode,
    output logic                  o_busy,
    output logic                  o_hw_protect,
    output logic                  o_protect_pin_enable,
    output logic                  o_volatility_indicator
);
    // ****************************************
    // Link domain
    // ****************************************
    sfd_pkg::sfd_link_t l;       // Link state
    sfd_pkg::sfd_link_t next_l;  // Link next state

    // Shift both forms; the core picks by mode, so the link never
    // needs the mode itself, which could not cross before edge one
    always_comb begin
        next_l = l;
        next_l.sh1 = {l.sh1[6:0], i_sio[0]};
        next_l.sh4 = {l.sh4[3:0], i_sio};
        if (l.cnt != `SFD_EDGES_1) begin
            next_l.cnt = l.cnt + 4'h1;
        end
        // Nibble opcode done after two edges
        if (l.cnt == `SFD_EDGES_Q - 4'h1) begin
            next_l.op4 = {l.sh4[3:0], i_sio};
            next_l.f4  = 1'b1;
        end
        // Serial opcode done after eight edges
        if (l.cnt == `SFD_EDGES_1 - 4'h1) begin
            next_l.op1 = {l.sh1[6:0], i_sio[0]};
            next_l.f1  = 1'b1;
        end
    end

    // Chip select high clears the frame; the clock is still then
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    function automatic sfd_pkg::sfd_dec_t decode(
        input logic [7:0] op,
        input logic       q,
        input logic       qpc,
        input logic       hwp
    );
        sfd_pkg::sfd_dec_t d;
        d = '0;
        d.ok = 1'b1;
        d.cmd.opcode = op;
        d.cmd.width = q ? sfd_pkg::SFD_IO4 : sfd_pkg::SFD_IO1;
        case (op)
            // No fields at all
            `SFD_OP_NOP, `SFD_OP_ARM, `SFD_OP_RST, `SFD_OP_XQ: begin
                d.ok = 1'b1;
            end
            `SFD_OP_WRITE_ENABLE_CMD, `SFD_OP_WRITE_DISABLE_CMD, `SFD_OP_CER: begin
                d.ok = 1'b1;
            end
            `SFD_OP_EQ: begin
                d.ok = !q;
            end
            // Register reads stream without limit
            `SFD_OP_READ_STATUS_CMD, `SFD_OP_READ_CONFIG_CMD: begin
                d.cmd.dummy = q ? `SFD_DUM1 : 2'h0;
                d.cmd.data_min = `SFD_ONE;
                d.cmd.data_unlim = 1'b1;
            end
            `SFD_OP_WRITE_STATUS_CMD: begin
                d.ok = !hwp;
                d.cmd.data_min = `SFD_WRITE_STATUS_CMD_N;
                d.cmd.data_max = `SFD_WRITE_STATUS_CMD_N;
            end
            `SFD_OP_WBPR: begin
                d.ok = !hwp;
                d.cmd.data_min = `SFD_ONE;
                d.cmd.data_max = `SFD_BPR_MAX;
            end
            `SFD_OP_FRD: begin
                d.cmd.addr_bytes = `SFD_ADDR3;
                d.cmd.dummy = q ? `SFD_DUM3 : `SFD_DUM1;
                d.cmd.data_min = `SFD_ONE;
                d.cmd.data_unlim = 1'b1;
            end
            // Single-wire reads on wider data lanes
            `SFD_OP_QOR, `SFD_OP_DOR, `SFD_OP_QIOR, `SFD_OP_DIOR: begin
                d.ok = !q;
                if (op == `SFD_OP_QOR || op == `SFD_OP_QIOR) begin
                    d.ok = !q && qpc;
                end
                d.cmd.addr_bytes = `SFD_ADDR3;
                d.cmd.dummy = (op == `SFD_OP_QIOR) ? `SFD_DUM3 : `SFD_DUM1;
                d.cmd.data_min = `SFD_ONE;
                d.cmd.data_unlim = 1'b1;
                d.cmd.width = (op == `SFD_OP_DOR || op == `SFD_OP_DIOR) ?
                              sfd_pkg::SFD_IO2 : sfd_pkg::SFD_IO4;
            end
            `SFD_OP_QWR, `SFD_OP_SWR: begin
                // Quad form in quad mode, the other single-wire only
                d.ok = (op == `SFD_OP_QWR) ? q : (!q && qpc);
                d.cmd.addr_bytes = `SFD_ADDR3;
                d.cmd.dummy = `SFD_DUM3;
                d.cmd.data_min = `SFD_BURST;
                d.cmd.data_unlim = 1'b1;
                d.cmd.width = sfd_pkg::SFD_IO4;
            end
            `SFD_OP_SER, `SFD_OP_BER: begin
                d.cmd.addr_bytes = `SFD_ADDR3;
            end
            `SFD_OP_PP: begin
                d.cmd.addr_bytes = `SFD_ADDR3;
                d.cmd.data_min = `SFD_ONE;
                d.cmd.data_max = `SFD_PAGE_MAX;
            end
            `SFD_OP_QPP: begin
                d.ok = !q && qpc;
                d.cmd.addr_bytes = `SFD_ADDR3;
                d.cmd.data_min = `SFD_ONE;
                d.cmd.data_max = `SFD_PAGE_MAX;
                d.cmd.width = sfd_pkg::SFD_IO4;
            end
            `SFD_OP_SB: begin
                d.cmd.data_min = `SFD_ONE;
                d.cmd.data_max = `SFD_ONE;
            end
            // Unknown opcode
            default: begin
                d.ok = 1'b0;
            end
        endcase
        return d;
    endfunction : decode

    // ****************************************
    // Core domain
    // ****************************************
    sfd_pkg::sfd_core_t s;       // Core state
    sfd_pkg::sfd_core_t next_s;  // Core next state
    sfd_pkg::sfd_dec_t  dec;     // Decode of current opcode
    logic               take;    // Opcode completes this cycle
    logic [7:0]         op;      // Opcode chosen by mode

    // Opcode arrival and busy timer
    always_comb begin
        next_s = s;
        next_s.f1s = {s.f1s[1:0], l.f1};
        next_s.f4s = {s.f4s[1:0], l.f4};
        next_s.wps = {s.wps[0], i_wp_n};
        next_s.cmd_v = 1'b0;
        next_s.cmd_rej = 1'b0;
        next_s.rst_p = 1'b0;
        // Pick the nibble or serial arrival by mode
        take = s.quad ? (s.f4s[1] && !s.f4s[2]) : (s.f1s[1] && !s.f1s[2]);
        op = s.quad ? l.op4 : l.op1;
        dec = decode(op, s.quad, i_quad_pin_config, s.hwp);
        next_s.hwp = !s.wps[1] && s.protect_pin_enable;
        // Busy runs down the self-timed enable-bit write
        if (s.busy) begin
            next_s.bcnt = s.bcnt - 20'h1;
            if (s.bcnt == 20'h1) begin
                next_s.busy = 1'b0;
            end
        end else if (i_protect_pin_enable_wr) begin
            next_s.protect_pin_enable = i_protect_pin_enable_val;
            next_s.busy = 1'b1;
            next_s.bcnt = 20'(PROTECT_ENABLE_WRITE_TIME_CYCLES);
        end
        // Lock only ever sets
        if (i_lock_set) begin
            next_s.locked = 1'b1;
        end
        // Indicator kept in a flop so the output comes straight off it
        next_s.ind = !next_s.locked;
        if (take) begin
            next_s.cmd = dec.cmd;
            next_s.cmd_v = dec.ok;
            next_s.cmd_rej = !dec.ok;
            // Every opcode but arm disarms
            next_s.armed = 1'b0;
            if (dec.ok) begin
                case (op)
                    `SFD_OP_ARM: begin
                        next_s.armed = 1'b1;
                    end
                    `SFD_OP_RST: begin
                        // Reset only acts after an arm
                        if (s.armed) begin
                            next_s.quad = 1'b0;
                            next_s.rst_p = 1'b1;
                        end
                    end
                    `SFD_OP_EQ: begin
                        next_s.quad = 1'b1;
                    end
                    `SFD_OP_XQ: begin
                        next_s.quad = 1'b0;
                    end
                    default: begin
                        next_s.armed = 1'b0;
                    end
                endcase
            end
        end
    end

    // Nonvolatile bits reload from the cells on reset
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s <= '0;
            s.protect_pin_enable <= i_nv_protect_pin_enable;
            s.locked <= i_nv_locked;
            s.ind <= !i_nv_locked;
            // Pin synchroniser starts at the idle high level, so no
            // false protect window opens right after reset
            s.wps <= 2'h3;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_cmd_valid = s.cmd_v;
    assign o_cmd_reject = s.cmd_rej;
    assign o_cmd = s.cmd;
    assign o_soft_reset = s.rst_p;
    assign o_quad_mode = s.quad;
    assign o_busy = s.busy;
    assign o_hw_protect = s.hwp;
    assign o_protect_pin_enable = s.protect_pin_enable;
    assign o_volatility_indicator = s.ind;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // Lock indicator drops on a lock and never comes back
    volat_ind_a: assert property (s.locked |=> s.locked && !o_volatility_indicator)
        else $error("volatility indicator returned high");
    lock_set_a: assert property (i_lock_set |=> !o_volatility_indicator)
        else $error("indicator still high after lock");
    // Protect follows pin and enable within the synchroniser delay;
    // checked against the raw pin so a broken sync chain shows up
    hw_prot_a: assert property ((!i_wp_n && s.protect_pin_enable) [*4] |-> o_hw_protect)
        else $error("hardware protect not raised");
    pin_high_a: assert property (i_wp_n [*4] |-> !o_hw_protect)
        else $error("hardware protect with pin high");
    enable_off_a: assert property (!s.protect_pin_enable [*4] |-> !o_hw_protect)
        else $error("hardware protect with enable clear");
    prot_rej_a: assert property (take && s.hwp && op == `SFD_OP_WRITE_STATUS_CMD |=> o_cmd_reject)
        else $error("status write passed under protect");
    // Self-timed enable write: busy holds and the bit stays put
    busy_hold_a: assert property (!s.busy && i_protect_pin_enable_wr |=> o_busy [*2])
        else $error("busy not held after enable write");
    busy_lock_a: assert property (s.busy |=> $stable(o_protect_pin_enable))
        else $error("enable bit changed while busy");
    // Mode legality of the opcodes
    quad_only_a: assert property (take && !s.quad && op == `SFD_OP_QWR |=> o_cmd_reject)
        else $error("quad wrap read taken in single mode");
    single_only_a: assert property (take && s.quad && op == `SFD_OP_QOR |=> o_cmd_reject)
        else $error("quad output read taken in quad mode");
    // Field counts handed on with the command
    status_dummy_a: assert property (take && op == `SFD_OP_READ_STATUS_CMD |=>
        o_cmd.dummy == (o_quad_mode ? `SFD_DUM1 : 2'h0) && o_cmd.data_unlim)
        else $error("status read fields wrong");
    fast_dummy_a: assert property (take && op == `SFD_OP_FRD |=>
        o_cmd_valid && o_cmd.dummy == (o_quad_mode ? `SFD_DUM3 : `SFD_DUM1))
        else $error("fast read dummy count wrong");
    dual_lane_a: assert property (take && !s.quad && op == `SFD_OP_DOR |=>
        o_cmd_valid && o_cmd.width == sfd_pkg::SFD_IO2)
        else $error("dual output read lanes wrong");
    erase_addr_a: assert property (
        take && (op == `SFD_OP_SER || op == `SFD_OP_BER) |=> o_cmd_valid &&
        o_cmd.addr_bytes == `SFD_ADDR3 && o_cmd.data_max == 9'h000 && !o_cmd.data_unlim)
        else $error("erase fields wrong");
    burst_len_a: assert property (take && op == `SFD_OP_SB |=>
        o_cmd.data_min == `SFD_ONE && o_cmd.data_max == `SFD_ONE)
        else $error("burst length field count wrong");
    page_len_a: assert property (take && op == `SFD_OP_PP |=>
        o_cmd.addr_bytes == `SFD_ADDR3 && o_cmd.data_max == `SFD_PAGE_MAX)
        else $error("page program fields wrong");
    // Reset arming: only an armed reset acts, anything else disarms
    disarm_a: assert property (take && op != `SFD_OP_ARM |=> !s.armed)
        else $error("reset stayed armed");
    soft_rst_a: assert property (take && op == `SFD_OP_RST && s.armed |=>
        o_soft_reset && !o_quad_mode)
        else $error("armed reset did not act");
    unarmed_rst_a: assert property (take && op == `SFD_OP_RST && !s.armed |=>
        !o_soft_reset)
        else $error("reset acted without arm");
    // Quad mode entry and exit
    quad_enter_a: assert property (take && !s.quad && op == `SFD_OP_EQ |=> o_quad_mode)
        else $error("quad mode not entered");
    quad_exit_a: assert property (take && op == `SFD_OP_XQ |=> !o_quad_mode)
        else $error("quad mode not left");
    qpc_gate_a: assert property (take && !s.quad && !i_quad_pin_config &&
        op == `SFD_OP_QPP |=> o_cmd_reject)
        else $error("quad page program without pin config");
endmodule : sfd_decoder

// *** sim/sfd_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Host controller model: one opcode a frame
// ****************************************
module sfd_host_model (
    output logic       o_sck,
    output logic       o_cs_n,
    output logic [3:0] o_sio
);
    // Idle: clock parked low, select high
    initial begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_sio  = 4'h5;
    end
    // Opcode goes MSB first; quad sends the high nibble first
    task automatic send(input logic [7:0] op, input logic quad);
        int n;
        n = quad ? 2 : 8;
        #37;
        o_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            o_sio = quad ? (i == 0 ? op[7:4] : op[3:0]) : {3'h0, op[7 - i]};
            #40;
            o_sck = 1'b1;
            #80;
            o_sck = 1'b0;
            #40;
        end
        // Select stays low well past the last edge so the answer lands
        #40;
        o_cs_n = 1'b1;
        // Released lines must not look like held data
        o_sio = ~o_sio;
        #100;
    endtask : send
endmodule : sfd_host_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
// Compare helper: counts each check, reports a mismatch at once
`define CHK(a, b) begin \
    compares++; \
    if ((a) !== (b)) begin \
        err_total++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
end
module tb;
    // ****************************************
    // Bench signals
    // ****************************************
    localparam int TW = 8;    // Short busy time keeps the run brief
    logic i_clk, rstn, sck, cs_n, wp_n, qpc;
    logic nv_protect_pin_enable, nv_lock;   // Bench copies of the nonvolatile cells
    logic wr, wval, lset, hq; // Enable write, lock pulse, host protocol
    logic [3:0] sio;
    logic cv, cr, srst, qm, busy, hwp, pen, vind;
    logic got_v, got_r, got_s; // Latched answers of the last frame
    sfd_pkg::sfd_cmd_t cmd;
    int   err_total, compares, cyc;
    sfd_decoder #(.PROTECT_ENABLE_WRITE_TIME_CYCLES(TW)) u_sfd_decoder (
        .i_clk(i_clk), .i_resetn(rstn), .i_sck(sck), .i_cs_n(cs_n),
        .i_sio(sio), .i_wp_n(wp_n), .i_quad_pin_config(qpc),
        .i_nv_protect_pin_enable(nv_protect_pin_enable), .i_nv_locked(nv_lock), .i_protect_pin_enable_wr(wr),
        .i_protect_pin_enable_val(wval), .i_lock_set(lset), .o_cmd_valid(cv),
        .o_cmd_reject(cr), .o_cmd(cmd), .o_soft_reset(srst), .o_quad_mode(qm),
        .o_busy(busy), .o_hw_protect(hwp), .o_protect_pin_enable(pen),
        .o_volatility_indicator(vind));
    sfd_host_model u_sfd_host_model (.o_sck(sck), .o_cs_n(cs_n), .o_sio(sio));
    // Core clock, 100 MHz
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Pulses are one cycle wide, so latch them; also cut a hang short
    always @(posedge i_clk) begin
        if (cv) got_v <= 1'b1;
        if (cr) got_r <= 1'b1;
        if (srst) got_s <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 25000) begin
            err_total++;
            wrap_up();
        end
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic do_reset;
        @(negedge i_clk);
        rstn = 1'b0;
        repeat (6) @(negedge i_clk);
        rstn = 1'b1;
        repeat (3) @(negedge i_clk);
    endtask : do_reset
    // One frame; e packs {addr, dummy, data_max, unlimited}
    task automatic op_chk(input logic [7:0] op, input logic ok, input logic [13:0] e);
        got_v = 1'b0;
        got_r = 1'b0;
        got_s = 1'b0;
        u_sfd_host_model.send(op, hq);
        @(negedge i_clk);
        `CHK({got_v, got_r}, {ok, !ok})
        if (ok) `CHK({cmd.opcode, cmd.addr_bytes, cmd.dummy, cmd.data_max, cmd.data_unlim}, {op, e})
    endtask : op_chk
    // Enable-bit write, then wait out busy before going on
    task automatic wen(input logic v);
        wr = 1'b1;
        wval = v;
        @(negedge i_clk);
        wr = 1'b0;
        nv_protect_pin_enable = v;
        repeat (TW + 2) @(negedge i_clk);
    endtask : wen
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_single;
        op_chk(8'h06, 1'b1, 14'h0000);
        op_chk(8'h04, 1'b1, 14'h0000);
        op_chk(8'hc7, 1'b1, 14'h0000);
        op_chk(8'h02, 1'b1, 14'h3200);
        op_chk(8'h05, 1'b1, 14'h0001);
        op_chk(8'h35, 1'b1, 14'h0001);
        op_chk(8'h01, 1'b1, 14'h0004);
        `CHK(cmd.data_min, 9'h002)
        op_chk(8'h0b, 1'b1, 14'h3401);
        op_chk(8'h6b, 1'b1, 14'h3401);
        op_chk(8'h3b, 1'b1, 14'h3401);
        `CHK(cmd.width, sfd_pkg::SFD_IO2)
        op_chk(8'h0c, 1'b0, 14'h0000);
        op_chk(8'hec, 1'b1, 14'h3c01);
        op_chk(8'h20, 1'b1, 14'h3000);
        op_chk(8'hd8, 1'b1, 14'h3000);
        op_chk(8'heb, 1'b1, 14'h3c01);
        op_chk(8'hbb, 1'b1, 14'h3401);
        op_chk(8'hc0, 1'b1, 14'h0002);
        op_chk(8'h32, 1'b1, 14'h3200);
        qpc = 1'b0;
        op_chk(8'h6b, 1'b0, 14'h0000);
        op_chk(8'hec, 1'b0, 14'h0000);
        op_chk(8'h32, 1'b0, 14'h0000);
        op_chk(8'h3b, 1'b1, 14'h3401);
    endtask : t_single
    // Quad mode; config bit left low since it does not apply here
    task automatic t_quad;
        op_chk(8'h38, 1'b1, 14'h0000);
        hq = 1'b1;
        `CHK(qm, 1'b1)
        op_chk(8'h05, 1'b1, 14'h0401);
        op_chk(8'h35, 1'b1, 14'h0401);
        op_chk(8'h0b, 1'b1, 14'h3c01);
        op_chk(8'h0c, 1'b1, 14'h3c01);
        `CHK({cmd.data_min, cmd.width}, {9'h008, sfd_pkg::SFD_IO4})
        op_chk(8'h6b, 1'b0, 14'h0000);
        op_chk(8'h3b, 1'b0, 14'h0000);
        op_chk(8'hec, 1'b0, 14'h0000);
        op_chk(8'heb, 1'b0, 14'h0000);
        op_chk(8'h38, 1'b0, 14'h0000);
        op_chk(8'h20, 1'b1, 14'h3000);
        op_chk(8'hc0, 1'b1, 14'h0002);
        op_chk(8'h01, 1'b1, 14'h0004);
        `CHK(qm, 1'b1)
        op_chk(8'hff, 1'b1, 14'h0000);
        hq = 1'b0;
        `CHK(qm, 1'b0)
    endtask : t_quad
    // Reset arming: a reset in quad mode, then disarming commands
    task automatic t_arm;
        op_chk(8'h38, 1'b1, 14'h0000);
        hq = 1'b1;
        op_chk(8'h66, 1'b1, 14'h0000);
        op_chk(8'h99, 1'b1, 14'h0000);
        hq = 1'b0;
        `CHK({got_s, qm}, 2'b10)
        op_chk(8'h66, 1'b1, 14'h0000);
        op_chk(8'h00, 1'b1, 14'h0000);
        op_chk(8'h99, 1'b1, 14'h0000);
        `CHK(got_s, 1'b0)
        op_chk(8'h66, 1'b1, 14'h0000);
        op_chk(8'h06, 1'b1, 14'h0000);
        op_chk(8'h99, 1'b1, 14'h0000);
        `CHK(got_s, 1'b0)
    endtask : t_arm
    // Busy time of the enable write; a second write meanwhile is dropped
    task automatic t_protect_pin_enable;
        int n;
        wr = 1'b1;
        wval = 1'b0;
        @(negedge i_clk);
        `CHK({busy, pen}, 2'b10)
        wval = 1'b1;
        @(negedge i_clk);
        wr = 1'b0;
        n = 1;
        while (busy === 1'b1 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        `CHK(n, TW)
        `CHK(pen, 1'b0)
        wen(1'b1);
        `CHK(pen, 1'b1)
    endtask : t_protect_pin_enable
    // Pin and enable both needed; only protection writes refused
    task automatic t_protect;
        wp_n = 1'b0;
        repeat (4) @(negedge i_clk);
        `CHK(hwp, 1'b1)
        op_chk(8'h01, 1'b0, 14'h0000);
        op_chk(8'h42, 1'b0, 14'h0000);
        op_chk(8'h02, 1'b1, 14'h3200);
        wp_n = 1'b1;
        repeat (4) @(negedge i_clk);
        `CHK(hwp, 1'b0)
        op_chk(8'h01, 1'b1, 14'h0004);
        op_chk(8'h42, 1'b1, 14'h0024);
        wen(1'b0);
        wp_n = 1'b0;
        repeat (4) @(negedge i_clk);
        `CHK(hwp, 1'b0)
    endtask : t_protect
    // Lock indicator drops and stays down across a reload
    task automatic t_lock;
        wen(1'b1);
        lset = 1'b1;
        @(negedge i_clk);
        lset = 1'b0;
        `CHK(vind, 1'b0)
        nv_lock = 1'b1;
        do_reset();
        `CHK({vind, pen}, 2'b01)
    endtask : t_lock
    task automatic wrap_up;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        {rstn, wr, wval, lset, nv_lock, hq, got_v, got_r, got_s} = 9'h000;
        {wp_n, qpc, nv_protect_pin_enable} = 3'h7;
        err_total = 0;
        compares = 0;
        cyc = 0;
        do_reset();
        `CHK({qm, busy, hwp, pen, vind}, 5'h03)
        t_single();
        t_quad();
        t_arm();
        t_protect_pin_enable();
        t_protect();
        t_lock();
        wrap_up();
    end
endmodule : tb
